/* File: ssst_cfg.svh */
/*
  Register offsets, field positions, reset values and timing counts
  for the synchronous serial transfer engine.
  Assumes a 25 MHz system clock and a 4-bit word address on the register port.
*/
`ifndef SSST_CFG_SVH
`define SSST_CFG_SVH

`define SSST_AW          4
`define SSST_A_CTRL      4'h0
`define SSST_A_STAT      4'h1
`define SSST_A_DATA      4'h2
`define SSST_A_DATA_HI   4'h3
`define SSST_A_BAUD      4'h4
`define SSST_A_CSC       4'h5
`define SSST_A_LEN       4'h6
`define SSST_A_WCNT      4'h7
`define SSST_A_FCNT      4'h8

`define SSST_B_SWRST     15
`define SSST_B_SLAVE     14
`define SSST_B_SPI       13
`define SSST_B_RIE       12
`define SSST_B_TIE       11
`define SSST_B_RXE       9
`define SSST_B_TXE       8
`define SSST_B_BDS       2
`define SSST_B_CLOCK_OUTPUT_ENABLE      1
`define SSST_B_SOE       0

`define SSST_B_RECEIVE_FULL_FLAG      10
`define SSST_B_TRANSMIT_EMPTY_FLAG      9
`define SSST_B_IDLE      8
`define SSST_B_WT_HI     4
`define SSST_B_WT_LO     3

`define SSST_B_SELECT_INPUT0_ENABLE     0
`define SSST_B_SELECT_OUTPUT_ENABLE      1
`define SSST_B_HOLD_SELECT_ACTIVE      2

`define SSST_CTRL_RST    16'h0000
`define SSST_BAUD_RST    15'h0001
`define SSST_LEN_RST     5'h08
`define SSST_LEN_MIN     5'h05
`define SSST_LEN_MAX     5'h10

`define SSST_CLK_MHZ     25
`define SSST_SETUP_NS    80
`define SSST_HOLD_NS     80
`define SSST_SETUP_CYC   18'((`SSST_SETUP_NS * `SSST_CLK_MHZ + 999) / 1000)
`define SSST_HOLD_CYC    18'((`SSST_HOLD_NS * `SSST_CLK_MHZ + 999) / 1000)

`endif

/* File: ssst_pkg.sv */
/*
  Types of the synchronous serial transfer engine: engine states and
  the packed state record of the core.
  Assumes ssst_cfg.svh is on the include path.
*/
package ssst_pkg;
  `include "ssst_cfg.svh"

  typedef enum logic [2:0] {
    SSST_IDLE,
    SSST_SETUP,
    SSST_LEAD,
    SSST_LOW,
    SSST_HIGH,
    SSST_HOLD,
    SSST_WAIT
  } ssst_st_t;

  typedef struct packed {
    ssst_st_t    st;
    logic [15:0] ctl;
    logic [1:0]  wt;
    logic [14:0] baud;
    logic [2:0]  csc;
    logic [4:0]  len;
    logic [7:0]  wcnt;
    logic [7:0]  pend;
    logic [7:0]  words;
    logic [15:0] txbuf;
    logic [15:0] sh;
    logic [15:0] rxsh;
    logic [15:0] rxbuf;
    logic        transmit_empty_flag;
    logic        receive_full_flag;
    logic        took;
    logic        loaded;
    logic [3:0]  idx;
    logic [17:0] cnt;
    logic        sck;
    logic        sdo;
    logic        cs_n;
    logic [2:0]  sck_s;
    logic [1:0]  cs_s;
    logic [1:0]  sdi_s;
    logic [15:0] rdata;
    logic        tirq;
    logic        rirq;
  } ssst_state_t;
endpackage

/* File: ssst_core.sv */
/*
  Clock-synchronous serial transfer engine: master and slave roles,
  normal transfer and SPI type I, optional chip select, register port.
  Assumes serial pins arrive asynchronously and the register master
  keeps strobes one cycle long.
*/
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps

module ssst_core
  import ssst_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [`SSST_AW-1:0]  addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [15:0]          rdata,
  output logic                      tx_irq,
  output logic                      rx_irq,
  input  wire logic                 sck_in,
  output logic                      sck_out,
  output logic                      sck_oe,
  input  wire logic                 sdi,
  output logic                      sdo,
  output logic                      sdo_oe,
  input  wire logic                 cs_in_n,
  output logic                      cs_out_n,
  output logic                      cs_oe
);

  ssst_state_t q;
  ssst_state_t d;

  logic        slave;
  logic        spi;
  logic        transmit_enable;
  logic        receive_enable;
  logic        serial_output_enable;
  logic        bds;
  logic        cs_use;
  logic [4:0]  len_e;
  logic [3:0]  last;
  logic [17:0] half_m1;
  logic [17:0] wait_m1;
  logic        s_fall;
  logic        s_rise;
  logic        s_act;
  logic        m_fin;
  logic        s_fin;

  assign slave   = q.ctl[`SSST_B_SLAVE];
  assign spi     = q.ctl[`SSST_B_SPI];
  assign transmit_enable     = q.ctl[`SSST_B_TXE];
  assign receive_enable     = q.ctl[`SSST_B_RXE];
  assign serial_output_enable     = q.ctl[`SSST_B_SOE];
  assign bds     = q.ctl[`SSST_B_BDS];
  assign cs_use  = q.csc[`SSST_B_SELECT_INPUT0_ENABLE] & q.csc[`SSST_B_SELECT_OUTPUT_ENABLE];
  // Out-of-range lengths are clamped rather than rejected
  assign len_e   = (q.len < `SSST_LEN_MIN) ? `SSST_LEN_MIN :
                   (q.len > `SSST_LEN_MAX) ? `SSST_LEN_MAX : q.len;
  assign last    = 4'(len_e - 5'h01);
  assign half_m1 = {3'h0, q.baud};
  assign wait_m1 = 18'(({30'h0, q.wt} * ({17'h0, q.baud} + 32'h1) * 32'h2) - 32'h1);
  // Edges come from the second and third stages only
  assign s_fall  = q.sck_s[2] & ~q.sck_s[1];
  assign s_rise  = ~q.sck_s[2] & q.sck_s[1];
  assign s_act   = ~q.csc[`SSST_B_SELECT_INPUT0_ENABLE] | ~q.cs_s[1];
  assign m_fin   = !slave && !q.ctl[`SSST_B_SWRST] && q.st == SSST_LOW &&
                   q.cnt == 18'h0 && q.idx == last;
  assign s_fin   = slave && !q.ctl[`SSST_B_SWRST] && s_act && s_fall && q.idx == last;

  function automatic logic [3:0] bitpos(input logic [3:0] i);
    bitpos = bds ? 4'(last - i) : i;
  endfunction

  always_comb begin
    logic        start;
    logic        go_lead;
    logic        more;
    logic        endcs;
    logic [7:0]  pend_n;
    logic [15:0] rx_w;
    start   = 1'b0;
    go_lead = 1'b0;
    more    = 1'b0;
    endcs   = 1'b0;
    pend_n  = q.pend;
    rx_w    = q.rxsh;
    d       = q;
    d.sck_s = {q.sck_s[1:0], sck_in};
    d.cs_s  = {q.cs_s[0], cs_in_n};
    d.sdi_s = {q.sdi_s[0], sdi};
    d.tirq  = q.transmit_empty_flag & q.ctl[`SSST_B_TIE];
    d.rirq  = q.receive_full_flag & q.ctl[`SSST_B_RIE];
    d.rdata = 16'h0000;

    if (rd_en) begin
      case (addr)
        `SSST_A_CTRL: d.rdata = q.ctl;
        `SSST_A_STAT: begin
          d.rdata[`SSST_B_RECEIVE_FULL_FLAG]  = q.receive_full_flag;
          d.rdata[`SSST_B_TRANSMIT_EMPTY_FLAG]  = q.transmit_empty_flag;
          d.rdata[`SSST_B_IDLE]  = (q.st == SSST_IDLE) && !q.loaded && q.idx == 4'h0;
          d.rdata[`SSST_B_WT_HI] = q.wt[1];
          d.rdata[`SSST_B_WT_LO] = q.wt[0];
        end
        `SSST_A_DATA: begin
          d.rdata = q.rxbuf;
          d.receive_full_flag  = 1'b0;
        end
        `SSST_A_BAUD: d.rdata = {1'b0, q.baud};
        `SSST_A_CSC:  d.rdata = {13'h0000, q.csc};
        `SSST_A_LEN:  d.rdata = {11'h000, len_e};
        `SSST_A_WCNT: d.rdata = {8'h00, q.wcnt};
        `SSST_A_FCNT: d.rdata = {8'h00, q.pend};
        default:      d.rdata = 16'h0000;
      endcase
    end

    if (wr_en) begin
      case (addr)
        `SSST_A_CTRL: d.ctl = wdata;
        `SSST_A_STAT: d.wt = {wdata[`SSST_B_WT_HI], wdata[`SSST_B_WT_LO]};
        `SSST_A_DATA: begin
          d.txbuf = wdata;
          d.transmit_empty_flag  = 1'b0;
        end
        `SSST_A_BAUD: d.baud = wdata[14:0];
        `SSST_A_CSC:  d.csc = wdata[2:0];
        `SSST_A_LEN:  d.len = wdata[4:0];
        `SSST_A_WCNT: d.wcnt = wdata[7:0];
        `SSST_A_FCNT: d.pend = wdata[7:0];
        default: begin
        end
      endcase
    end

    if (!slave) begin
      case (q.st)
        SSST_IDLE: begin
          d.sck = 1'b1;
          // Dummy writes and frame counts both start master clocks
          if (transmit_enable && (!q.transmit_empty_flag || q.pend != 8'h00)) begin
            start = 1'b1;
          end else if (!q.cs_n && !q.csc[`SSST_B_HOLD_SELECT_ACTIVE] && q.words == 8'h00) begin
            d.cs_n = 1'b1;
          end
        end
        SSST_SETUP: begin
          if (q.cnt == 18'h0) begin
            go_lead = 1'b1;
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        SSST_LEAD: begin
          if (q.cnt == 18'h0) begin
            d.st  = SSST_LOW;
            d.sck = 1'b0;
            d.cnt = half_m1;
            rx_w[bitpos(q.idx)] = q.sdi_s[1];
            d.rxsh = rx_w;
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        SSST_LOW: begin
          if (q.cnt == 18'h0) begin
            d.sck = 1'b1;
            d.cnt = half_m1;
            if (q.idx != last) begin
              d.st  = SSST_HIGH;
              d.idx = q.idx + 4'h1;
              d.sdo = serial_output_enable ? q.sh[bitpos(q.idx + 4'h1)] : 1'b1;
            end else begin
              d.rxbuf = q.rxsh;
              d.idx   = 4'h0;
              d.words = q.words + 8'h01;
              if (q.pend != 8'h00) begin
                pend_n = q.pend - 8'h01;
              end
              d.pend = pend_n;
              more   = transmit_enable && (!q.transmit_empty_flag || pend_n != 8'h00);
              // Word count zero means select ends when data runs out
              endcs  = cs_use && ((q.wcnt == 8'h00) ? !more :
                                  (q.words + 8'h01 == q.wcnt));
              if (endcs) begin
                d.st    = SSST_HOLD;
                d.cnt   = `SSST_HOLD_CYC - 18'h1;
                d.words = 8'h00;
              end else if (more && q.wt != 2'b00) begin
                d.st  = SSST_WAIT;
                d.cnt = wait_m1;
              end else if (more) begin
                start = 1'b1;
              end else begin
                d.st = SSST_IDLE;
              end
            end
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        SSST_HIGH: begin
          if (q.cnt == 18'h0) begin
            d.st  = SSST_LOW;
            d.sck = 1'b0;
            d.cnt = half_m1;
            rx_w[bitpos(q.idx)] = q.sdi_s[1];
            d.rxsh = rx_w;
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        SSST_HOLD: begin
          if (q.cnt == 18'h0) begin
            d.cs_n = ~q.csc[`SSST_B_HOLD_SELECT_ACTIVE];
            d.st   = SSST_IDLE;
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        SSST_WAIT: begin
          if (q.cnt == 18'h0) begin
            if (transmit_enable && (!q.transmit_empty_flag || q.pend != 8'h00)) begin
              start = 1'b1;
            end else begin
              d.st = SSST_IDLE;
            end
          end else begin
            d.cnt = q.cnt - 18'h1;
          end
        end
        default: d.st = SSST_IDLE;
      endcase

      if (start) begin
        d.sh   = q.transmit_empty_flag ? 16'h0000 : q.txbuf;
        d.took = !q.transmit_empty_flag;
        d.idx  = 4'h0;
        // Bits beyond a short frame read as zero, not stale data
        d.rxsh = 16'h0000;
        d.sck  = 1'b1;
        if (spi) begin
          d.sdo = serial_output_enable ? d.sh[bitpos(4'h0)] : 1'b1;
        end
        if (cs_use && q.cs_n) begin
          d.cs_n = 1'b0;
          d.st   = SSST_SETUP;
          d.cnt  = `SSST_SETUP_CYC - 18'h1;
        end else begin
          go_lead = 1'b1;
        end
      end
      if (go_lead) begin
        d.st  = SSST_LEAD;
        d.cnt = half_m1;
        if (start ? !q.transmit_empty_flag : q.took) begin
          d.transmit_empty_flag = 1'b1;
        end
        if (!spi) begin
          d.sdo = serial_output_enable ? d.sh[bitpos(4'h0)] : 1'b1;
        end
      end
    end else begin
      d.st   = SSST_IDLE;
      d.sck  = 1'b1;
      d.cs_n = 1'b1;
      if (!s_act) begin
        d.loaded = 1'b0;
        d.rxsh   = 16'h0000;
        d.idx    = 4'h0;
        d.sdo    = 1'b1;
      end else begin
        if (transmit_enable && !q.loaded && !q.transmit_empty_flag && q.idx == 4'h0) begin
          d.sh     = q.txbuf;
          d.transmit_empty_flag   = 1'b1;
          d.loaded = 1'b1;
          d.sdo    = serial_output_enable ? q.txbuf[bitpos(4'h0)] : 1'b1;
        end
        if (s_fall) begin
          rx_w[bitpos(q.idx)] = q.sdi_s[1];
          d.rxsh = rx_w;
          if (q.idx == last) begin
            d.rxbuf  = rx_w;
            d.rxsh   = 16'h0000;
            d.idx    = 4'h0;
            d.loaded = 1'b0;
          end else begin
            d.idx = q.idx + 4'h1;
          end
        end
        if (s_rise && q.loaded && q.idx != 4'h0) begin
          d.sdo = serial_output_enable ? q.sh[bitpos(q.idx)] : 1'b1;
        end
      end
    end

    if ((m_fin || s_fin) && receive_enable) begin
      d.receive_full_flag = 1'b1;
    end

    // Software reset aborts the frame but keeps the configuration
    if (q.ctl[`SSST_B_SWRST]) begin
      d.st     = SSST_IDLE;
      d.sck    = 1'b1;
      d.cs_n   = 1'b1;
      d.sdo    = 1'b1;
      d.transmit_empty_flag   = 1'b1;
      d.receive_full_flag   = 1'b0;
      d.idx    = 4'h0;
      d.loaded = 1'b0;
      d.pend   = 8'h00;
      d.words  = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.st    <= SSST_IDLE;
      q.ctl   <= `SSST_CTRL_RST;
      q.baud  <= `SSST_BAUD_RST;
      q.len   <= `SSST_LEN_RST;
      q.transmit_empty_flag  <= 1'b1;
      q.sck   <= 1'b1;
      q.sdo   <= 1'b1;
      q.cs_n  <= 1'b1;
      q.sck_s <= 3'h7;
      q.cs_s  <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign rdata    = q.rdata;
  assign tx_irq   = q.tirq;
  assign rx_irq   = q.rirq;
  assign sck_out  = q.sck;
  assign sck_oe   = q.ctl[`SSST_B_CLOCK_OUTPUT_ENABLE];
  assign sdo      = q.sdo;
  assign sdo_oe   = q.ctl[`SSST_B_SOE];
  assign cs_out_n = q.cs_n;
  assign cs_oe    = q.csc[`SSST_B_SELECT_OUTPUT_ENABLE];

  logic endcs_chk;
  assign endcs_chk = cs_use && ((q.wcnt == 8'h00) ? 1'b0 : (q.words + 8'h01 == q.wcnt));

  a_transmit_empty_flag_wr_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && addr == `SSST_A_DATA && !slave && q.st == SSST_IDLE &&
    !q.ctl[`SSST_B_SWRST] |=> !q.transmit_empty_flag)
    else $error("empty flag not cleared by data write");

  a_rx_full_set: assert property (@(posedge sys_clk) disable iff (rst)
    (m_fin || s_fin) && receive_enable |=> q.receive_full_flag && q.rxbuf == $past(d.rxbuf))
    else $error("full flag or data missing after last bit");

  a_rx_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && addr == `SSST_A_DATA && !m_fin && !s_fin |=> !q.receive_full_flag)
    else $error("full flag not cleared by data read");

  a_sck_idle_high: assert property (@(posedge sys_clk) disable iff (rst)
    q.st == SSST_IDLE || q.st == SSST_SETUP || q.st == SSST_HOLD |-> q.sck)
    else $error("serial clock not at idle high");

  a_cs_setup_gap: assert property (@(posedge sys_clk) disable iff (rst)
    !slave && $fell(q.cs_n) |-> q.sck [*2] ##1 q.st == SSST_LEAD)
    else $error("clock started inside select setup time");

  a_cs_hold_end: assert property (@(posedge sys_clk) disable iff (rst)
    q.st == SSST_HOLD && q.cnt == 18'h0 && !q.ctl[`SSST_B_SWRST] |=>
    q.cs_n == !$past(q.csc[`SSST_B_HOLD_SELECT_ACTIVE]))
    else $error("select level wrong after hold time");

  a_word_stop: assert property (@(posedge sys_clk) disable iff (rst)
    m_fin && cs_use && q.wcnt != 8'h00 && q.words + 8'h01 == q.wcnt |=>
    q.st == SSST_HOLD && q.sck && q.words == 8'h00)
    else $error("clock not stopped at word count");

  a_frame_wait: assert property (@(posedge sys_clk) disable iff (rst)
    m_fin && !endcs_chk && q.wt != 2'b00 && transmit_enable && (!q.transmit_empty_flag || q.pend > 8'h01) |=>
    q.st == SSST_WAIT)
    else $error("no wait inserted between frames");

  a_slave_release: assert property (@(posedge sys_clk) disable iff (rst)
    slave && !s_act && !q.ctl[`SSST_B_SWRST] |=> q.sdo && !q.loaded)
    else $error("slave data out not high after select release");

  a_spi_first_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !slave && spi && serial_output_enable && q.st == SSST_SETUP |-> q.sdo == q.sh[bitpos(4'h0)])
    else $error("first bit not presented before clocking");

  a_lead_transmit_empty_flag: assert property (@(posedge sys_clk) disable iff (rst)
    q.st == SSST_LEAD && $past(q.st) != SSST_LEAD && q.took |-> q.transmit_empty_flag)
    else $error("empty flag late before first falling edge");

  a_len_range: assert property (@(posedge sys_clk) disable iff (rst)
    len_e >= `SSST_LEN_MIN && len_e <= `SSST_LEN_MAX && q.idx <= last)
    else $error("frame length outside range");

endmodule

/* File: ssst_peer.sv */
/*
  Serial peer of the transfer engine: a slave while the engine masters the link,
  a master driving a 320 ns link clock while the engine is the slave.
  Assumes an idle-high clock and words sent least significant bit first.
*/
`timescale 1ns/1ps
module ssst_peer (
  input  wire logic sck_out,
  input  wire logic sdo,
  input  wire logic cs_out_n,
  output logic      sck_in,
  output logic      sdi,
  output logic      cs_in_n
);
  logic        mst = 1'b0;
  logic        m_sdi = 1'b1;
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  int          len = 8;
  int          idx = 0;

  initial begin
    sck_in = 1'b1;
    cs_in_n = 1'b1;
  end

  // Released line shows the inverse, so stale data never passes
  assign sdi = mst ? m_sdi : (cs_out_n ? ~tx_word[idx] : tx_word[idx]);

  task automatic arm(input logic [15:0] wd, input int n);
    mst = 1'b0;
    tx_word = wd;
    rx_word = 16'h0000;
    len = n;
    idx = 0;
  endtask

  always @(negedge cs_out_n) idx = 0;
  always @(posedge sck_out) begin
    if (!cs_out_n && !mst) idx = (idx + 1 == len) ? 0 : idx + 1;
  end
  always @(negedge sck_out) begin
    if (!cs_out_n && !mst) rx_word = {sdo, rx_word[15:1]};
  end

  // Clock stands high outside frames; select spans the whole frame
  task automatic frame(input logic [15:0] wd, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    mst = 1'b1;
    #13 cs_in_n = 1'b0;
    #320;
    for (int i = 0; i < n; i++) begin
      m_sdi = wd[i];
      #160 rx[i] = sdo;
      sck_in = 1'b0;
      #160 sck_in = 1'b1;
    end
    #160 cs_in_n = 1'b1;
    m_sdi = ~m_sdi;
  endtask
endmodule

/* File: ssst_core_tb.sv */
/*
  Self-checking bench of the transfer engine: register port tasks, master
  and slave frames against the serial peer, read results checked from a queue.
  Assumes ssst_cfg.svh on the include path and a 25 MHz system clock.
*/
`timescale 1ns/1ps
`include "ssst_cfg.svh"
module ssst_core_tb
  import ssst_pkg::*;
;
  typedef struct packed {logic [15:0] exp; logic [15:0] msk;} ssst_note_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        rd_d1 = 1'b0;
  logic        sck_d = 1'b1;
  logic [15:0] rdata, last_rd, w, pw, mk, got, s;
  logic        tx_irq, rx_irq, sck_in, sck_out, sck_oe, sdi, sdo, sdo_oe;
  logic        cs_in_n, cs_out_n, cs_oe;
  logic [31:0] seed = 32'h0000BBB3;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          lowc = 0;
  int          falls = 0;
  int          base = 0;
  int          ln = 0;
  ssst_note_t  cur;
  ssst_note_t  note_q[$];

  ssst_core u_ssst_core (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .cs_in_n(cs_in_n), .cs_out_n(cs_out_n), .cs_oe(cs_oe));
  ssst_peer u_ssst_peer (.sck_out(sck_out), .sdo(sdo), .cs_out_n(cs_out_n),
    .sck_in(sck_in), .sdi(sdi), .cs_in_n(cs_in_n));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    note_q.push_back({e, m});
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  task automatic rd_raw(input logic [3:0] a, output logic [15:0] v);
    rd(a, 16'h0000, 16'h0000);
    @(posedge sys_clk);
    #1 v = last_rd;
  endtask

  // Write then status read back to back: the flag is seen before the lead-in starts
  task automatic wr_first(input logic [15:0] d);
    @(posedge sys_clk);
    addr <= `SSST_A_DATA;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr <= `SSST_A_STAT;
    rd_en <= 1'b1;
    note_q.push_back({16'h0000, 16'h0200});
    @(posedge sys_clk);
    rd_en <= 1'b0;
    // Select and first bit appear one cycle after the write lands
    #1 chk16({13'h0, cs_out_n, sck_out, sdo}, {13'h0, 1'b0, 1'b1, d[0]});
  endtask

  task automatic wait_cs(input logic lv);
    int n;
    n = 0;
    while (cs_out_n !== lv && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 2000) chk16({15'h0, cs_out_n}, {15'h0, lv});
  endtask

  task automatic wait_full();
    logic [15:0] v;
    int n;
    v = 16'h0000;
    n = 0;
    while (v[`SSST_B_RECEIVE_FULL_FLAG] !== 1'b1 && n < 300) begin
      rd_raw(`SSST_A_STAT, v);
      n++;
    end
    if (n == 300) chk16(v & 16'h0400, 16'h0400);
  endtask

  always @(posedge sys_clk) begin
    rd_d1 <= rd_en;
    if (rd_d1 && note_q.size() > 0) begin
      cur = note_q.pop_front();
      last_rd = rdata;
      if (cur.msk !== 16'h0000) chk16(rdata & cur.msk, cur.exp);
    end
  end

  // Tests need under 1000 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sck_d <= sck_out;
    if (!cs_out_n) lowc <= lowc + 1;
    if (!cs_out_n && sck_d && !sck_out) falls <= falls + 1;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`SSST_A_CTRL, 16'h0000, 16'hFFFF);
    rd(`SSST_A_STAT, 16'h0200, 16'h0600);
    rd(`SSST_A_BAUD, 16'h0001, 16'hFFFF);
    rd(`SSST_A_LEN, 16'h0008, 16'hFFFF);
    wr(`SSST_A_STAT, 16'hFFFF);
    rd(`SSST_A_STAT, 16'h0218, 16'h0618);
    wr(4'hF, rnd());
    rd(4'hF, 16'h0000, 16'hFFFF);
    rd(`SSST_A_DATA_HI, 16'h0000, 16'hFFFF);
    wr(`SSST_A_LEN, 16'h0002);
    rd(`SSST_A_LEN, 16'h0005, 16'hFFFF);
    wr(`SSST_A_LEN, 16'h001F);
    rd(`SSST_A_LEN, 16'h0010, 16'hFFFF);
    wr(`SSST_A_STAT, 16'h0000);
    // Three-cycle half period: the data input synchroniser needs two of them
    wr(`SSST_A_BAUD, 16'h0002);
    wr(`SSST_A_CSC, 16'h0003);
    wr(`SSST_A_CTRL, 16'h2303);
    for (int k = 0; k < 3; k++) begin
      ln = (k == 0) ? 5 : (k == 1) ? 16 : 5 + int'(rnd() % 16'd12);
      w = rnd();
      pw = rnd();
      mk = 16'((32'h1 << ln) - 1);
      u_ssst_peer.arm(pw, ln);
      wr(`SSST_A_LEN, 16'(ln));
      wr(`SSST_A_WCNT, 16'h0001);
      wr_first(w);
      wait_full();
      rd(`SSST_A_DATA, pw & mk, 16'hFFFF);
      rd(`SSST_A_STAT, 16'h0000, 16'h0400);
      wait_cs(1'b1);
      chk16(u_ssst_peer.rx_word >> (16 - ln), w & mk);
      chk16({15'h0, sck_out}, 16'h0001);
    end
    // Two frames per run; each wait code must stretch the select window exactly
    wr(`SSST_A_LEN, 16'h0005);
    wr(`SSST_A_WCNT, 16'h0002);
    for (int wt = 0; wt < 4; wt++) begin
      wr(`SSST_A_STAT, 16'(wt << 3));
      #1;
      lowc = 0;
      falls = 0;
      wr(`SSST_A_FCNT, 16'h0002);
      wait_cs(1'b0);
      wait_cs(1'b1);
      chk16(16'(falls), 16'h000A);
      if (wt == 0) base = lowc;
      else chk16(16'(lowc - base), 16'(wt * 6));
      rd_raw(`SSST_A_DATA, s);
    end
    wr(`SSST_A_CSC, 16'h0007);
    wr(`SSST_A_WCNT, 16'h0001);
    wr(`SSST_A_DATA, rnd());
    wait_full();
    repeat (20) @(posedge sys_clk);
    chk16({15'h0, cs_out_n}, 16'h0000);
    rd_raw(`SSST_A_DATA, s);
    wr(`SSST_A_CSC, 16'h0001);
    wr(`SSST_A_CTRL, 16'h6301);
    wr(`SSST_A_LEN, 16'h0008);
    w = rnd();
    pw = rnd();
    wr(`SSST_A_DATA, w);
    repeat (4) @(posedge sys_clk);
    chk16({15'h0, sdo}, 16'h0001);
    u_ssst_peer.frame(pw, 8, got);
    chk16(got, {8'h00, w[7:0]});
    repeat (4) @(posedge sys_clk);
    chk16({15'h0, sdo}, 16'h0001);
    rd(`SSST_A_DATA, {8'h00, pw[7:0]}, 16'h00FF);
    u_ssst_peer.frame(rnd(), 3, got);
    repeat (6) @(posedge sys_clk);
    rd(`SSST_A_STAT, 16'h0000, 16'h0400);
    u_ssst_peer.frame(~pw, 8, got);
    wait_full();
    rd(`SSST_A_DATA, {8'h00, ~pw[7:0]}, 16'h00FF);
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule
